// ==== inc/beam_area_pkg.sv ====
package beam_area_pkg;
  // beam array geometry
  localparam int NUM_BEAMS = 64;
  localparam int NUM_AREAS = 32;
  localparam logic [15:0] BEAM_FIRST = 16'h0001;
  localparam logic [15:0] BEAM_LAST = 16'h0040;
  // special bound codes selecting tracking bounds
  localparam logic [15:0] START_DYNAMIC = 16'hfffe;
  localparam logic [15:0] END_DYNAMIC = 16'hfffc;
  // register word addresses
  localparam logic [7:0] REG_PIN_DIR = 8'h00;
  localparam logic [7:0] REG_PIN_POLARITY = 8'h01;
  localparam logic [7:0] REG_PIN_FUNC = 8'h02;
  localparam logic [7:0] REG_AREA_MASK = 8'h03;
  localparam logic [7:0] REG_AREA_STATE = 8'h04;
  localparam logic [7:0] REG_BOUNDS = 8'h05;
  localparam logic [7:0] REG_STATUS = 8'h06;
  localparam int AREA_WINDOW_BIT = 7;
  // per-area word selectors inside the area window
  localparam logic [1:0] AREA_W_CTRL = 2'h0;
  localparam logic [1:0] AREA_W_BOUNDS = 2'h1;
  localparam logic [1:0] AREA_W_THRESH = 2'h2;
  // field positions
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_LOGIC_BIT = 1;
  localparam int LOW_HALF_LSB = 0;
  localparam int HIGH_HALF_LSB = 16;
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_NONE_BIT = 1;
  // setting encodings
  localparam logic PIN_AS_OUTPUT = 1'b0;
  localparam logic [7:0] FUNC_AREA_OUTPUT = 8'h01;
  localparam logic LOGIC_LIGHT = 1'b0;
  // reset values
  localparam logic RST_PIN_DIR = 1'b0;
  localparam logic RST_PIN_POLARITY = 1'b0;
  localparam logic [7:0] RST_PIN_FUNC = 8'h00;
  localparam logic [31:0] RST_AREA_MASK = 32'h0000_0000;
  // evaluation states
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_FETCH_CTRL = 3'b001,
    S_FETCH_BOUNDS = 3'b010,
    S_FETCH_THRESH = 3'b011,
    S_TAKE_THRESH = 3'b100,
    S_EVAL = 3'b101,
    S_OUTPUT = 3'b110
  } eval_state_e;
endpackage : beam_area_pkg

// ==== hdl/area_mem.sv ====
`timescale 1ns/1ps
// per-area settings store, one write port, two registered read ports
module area_mem (
  // clock
  input wire logic sys_clk,
  // software port
  input wire logic [6:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_we,
  output logic [31:0] bus_rdata,
  // evaluation port
  input wire logic [6:0] eval_addr,
  output logic [31:0] eval_rdata
);
  logic [31:0] mem [0:127];

  // write port
  always_ff @(posedge sys_clk) begin
    if (bus_we) begin
      mem[bus_addr] <= bus_wdata;
    end
  end

  // registered read ports
  always_ff @(posedge sys_clk) begin
    bus_rdata <= mem[bus_addr];
    eval_rdata <= mem[eval_addr];
  end
endmodule : area_mem

// ==== hdl/beam_area_output_mapping.sv ====
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
//Contract
// - only enabled areas evaluated and mappable
// - light switching: state on free beams
// - start is fixed beam or first blocked
// - start code 65534 selects dynamic start
// - end is fixed beam or last blocked
// - end code 65532 selects dynamic end
// - ON threshold reached switches state on
// - separate OFF threshold per area
// - pin drives when direction is 0
// - function 1 drives pin from areas
// - polarity 1 inverts pin level
// - mask ORs selected areas, bit0 area1
// - dynamic bounds are first/last blocked beams
module beam_area_output_mapping (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // beam scan input
  input wire logic [63:0] scan_blocked,
  input wire logic scan_valid,
  // switching output pin 2
  output logic pin2_out,
  output logic pin2_oe,
  // scan done pulse
  output logic eval_done
);
  // settings registers
  logic pin_dir;
  logic pin_polarity;
  logic [7:0] pin_func;
  logic [31:0] area_mask;
  // evaluation state
  beam_area_pkg::eval_state_e state;
  logic [4:0] area_idx;
  logic [63:0] scan_vec;
  logic [15:0] first_blocked_beam;
  logic [15:0] last_blocked_beam;
  logic none_blocked;
  logic [31:0] area_state;
  logic area_enable;
  logic area_logic;
  logic [15:0] area_start;
  logic [15:0] area_end;
  logic [15:0] area_on;
  logic [15:0] area_off;
  // register port helpers
  logic area_hit;
  logic rd_area_q;
  logic [31:0] rd_local_q;
  logic [31:0] mem_bus_rdata;
  logic [31:0] mem_eval_rdata;
  logic [6:0] eval_addr;
  logic [15:0] lo_bound;
  logic [15:0] hi_bound;
  logic [15:0] beam_count;
  logic next_state_bit;
  logic next_pin;

  // first blocked beam number, zero when none
  function automatic logic [15:0] find_first(input logic [63:0] vec);
    logic [15:0] n;
    n = 16'h0000;
    for (int i = beam_area_pkg::NUM_BEAMS - 1; i >= 0; i--) begin
      if (vec[i]) begin
        n = 16'(i + 1);
      end
    end
    return n;
  endfunction : find_first

  // last blocked beam number, zero when none
  function automatic logic [15:0] find_last(input logic [63:0] vec);
    logic [15:0] n;
    n = 16'h0000;
    for (int i = 0; i < beam_area_pkg::NUM_BEAMS; i++) begin
      if (vec[i]) begin
        n = 16'(i + 1);
      end
    end
    return n;
  endfunction : find_last

  // count beams in [lo,hi] whose blocked bit equals want
  function automatic logic [15:0] count_beams(input logic [63:0] vec, input logic [15:0] lo,
                                              input logic [15:0] hi, input logic want);
    logic [15:0] c;
    logic [15:0] b;
    c = 16'h0000;
    b = 16'h0000;
    for (int i = 0; i < beam_area_pkg::NUM_BEAMS; i++) begin
      b = 16'(i + 1);
      if (b >= lo && b <= hi && vec[i] == want) begin
        c = c + 16'h0001;
      end
    end
    return c;
  endfunction : count_beams

  assign area_hit = reg_addr[beam_area_pkg::AREA_WINDOW_BIT];

  // settings store for the 32 areas
  area_mem u_area_mem (
    .sys_clk(sys_clk),
    .bus_addr(reg_addr[6:0]),
    .bus_wdata(reg_wdata),
    .bus_we(reg_wr && area_hit),
    .bus_rdata(mem_bus_rdata),
    .eval_addr(eval_addr),
    .eval_rdata(mem_eval_rdata)
  );

  // pin settings written by software
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pin_dir <= beam_area_pkg::RST_PIN_DIR;
      pin_polarity <= beam_area_pkg::RST_PIN_POLARITY;
      pin_func <= beam_area_pkg::RST_PIN_FUNC;
      area_mask <= beam_area_pkg::RST_AREA_MASK;
    end else if (reg_wr && !area_hit) begin
      case (reg_addr)
        beam_area_pkg::REG_PIN_DIR: pin_dir <= reg_wdata[0];
        beam_area_pkg::REG_PIN_POLARITY: pin_polarity <= reg_wdata[0];
        beam_area_pkg::REG_PIN_FUNC: pin_func <= reg_wdata[7:0];
        beam_area_pkg::REG_AREA_MASK: area_mask <= reg_wdata;
        default: ;
      endcase
    end
  end

  // local read mux, captured with the strobe
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rd_local_q <= 32'h0000_0000;
      rd_area_q <= 1'b0;
    end else begin
      rd_area_q <= reg_rd && area_hit;
      rd_local_q <= 32'h0000_0000;
      if (reg_rd && !area_hit) begin
        case (reg_addr)
          beam_area_pkg::REG_PIN_DIR: rd_local_q <= {31'h0, pin_dir};
          beam_area_pkg::REG_PIN_POLARITY: rd_local_q <= {31'h0, pin_polarity};
          beam_area_pkg::REG_PIN_FUNC: rd_local_q <= {24'h0, pin_func};
          beam_area_pkg::REG_AREA_MASK: rd_local_q <= area_mask;
          beam_area_pkg::REG_AREA_STATE: rd_local_q <= area_state;
          beam_area_pkg::REG_BOUNDS: rd_local_q <= {last_blocked_beam, first_blocked_beam};
          beam_area_pkg::REG_STATUS: rd_local_q <= {30'h0, none_blocked,
                                                    state != beam_area_pkg::S_IDLE};
          default: rd_local_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // read data: area words come from the store, unused word 3 reads zero
  logic rd_word3_q;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rd_word3_q <= 1'b0;
    end else begin
      rd_word3_q <= reg_addr[1:0] == 2'h3;
    end
  end

  assign reg_rdata = (rd_area_q && !rd_word3_q) ? mem_bus_rdata : rd_local_q;

  // evaluation read address follows the fetch step
  always_comb begin
    eval_addr = {area_idx, beam_area_pkg::AREA_W_CTRL};
    case (state)
      beam_area_pkg::S_FETCH_BOUNDS: eval_addr = {area_idx, beam_area_pkg::AREA_W_BOUNDS};
      beam_area_pkg::S_FETCH_THRESH: eval_addr = {area_idx, beam_area_pkg::AREA_W_THRESH};
      default: eval_addr = {area_idx, beam_area_pkg::AREA_W_CTRL};
    endcase
  end

  // area bounds, fixed or tracking the blocked beams
  always_comb begin
    lo_bound = area_start;
    hi_bound = area_end;
    if (area_start == beam_area_pkg::START_DYNAMIC) begin
      lo_bound = first_blocked_beam;
    end
    if (area_end == beam_area_pkg::END_DYNAMIC) begin
      hi_bound = last_blocked_beam;
    end
    // a tracking bound with nothing blocked leaves the area empty
    if (none_blocked && (area_start == beam_area_pkg::START_DYNAMIC ||
                         area_end == beam_area_pkg::END_DYNAMIC)) begin
      lo_bound = beam_area_pkg::BEAM_LAST;
      hi_bound = beam_area_pkg::BEAM_FIRST;
    end
  end

  // free beams for light switching, blocked beams for dark switching
  assign beam_count = count_beams(scan_vec, lo_bound, hi_bound,
                                  area_logic != beam_area_pkg::LOGIC_LIGHT);

  // two-threshold hysteresis of one area
  always_comb begin
    next_state_bit = area_state[area_idx];
    if (!area_enable) begin
      next_state_bit = 1'b0;
    end else if (beam_count >= area_on) begin
      next_state_bit = 1'b1;
    end else if (beam_count <= area_off) begin
      next_state_bit = 1'b0;
    end
  end

  // pin level from the masked area states
  always_comb begin
    next_pin = 1'b0;
    if (pin_func == beam_area_pkg::FUNC_AREA_OUTPUT) begin
      next_pin = |(area_state & area_mask);
    end
    next_pin = next_pin ^ pin_polarity;
  end

  // scan sequencer: latch scan, walk all areas, then update the pin
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= beam_area_pkg::S_IDLE;
      area_idx <= 5'h00;
      scan_vec <= 64'h0;
      first_blocked_beam <= 16'h0000;
      last_blocked_beam <= 16'h0000;
      none_blocked <= 1'b1;
    end else begin
      case (state)
        beam_area_pkg::S_IDLE: begin
          if (scan_valid) begin
            scan_vec <= scan_blocked;
            first_blocked_beam <= find_first(scan_blocked);
            last_blocked_beam <= find_last(scan_blocked);
            none_blocked <= scan_blocked == 64'h0;
            area_idx <= 5'h00;
            state <= beam_area_pkg::S_FETCH_CTRL;
          end
        end
        beam_area_pkg::S_FETCH_CTRL: state <= beam_area_pkg::S_FETCH_BOUNDS;
        beam_area_pkg::S_FETCH_BOUNDS: state <= beam_area_pkg::S_FETCH_THRESH;
        beam_area_pkg::S_FETCH_THRESH: state <= beam_area_pkg::S_TAKE_THRESH;
        beam_area_pkg::S_TAKE_THRESH: state <= beam_area_pkg::S_EVAL;
        beam_area_pkg::S_EVAL: begin
          area_idx <= area_idx + 5'h01;
          if (area_idx == 5'h1f) begin
            state <= beam_area_pkg::S_OUTPUT;
          end else begin
            state <= beam_area_pkg::S_FETCH_CTRL;
          end
        end
        beam_area_pkg::S_OUTPUT: state <= beam_area_pkg::S_IDLE;
        default: state <= beam_area_pkg::S_IDLE;
      endcase
    end
  end

  // capture area settings as the store answers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      area_enable <= 1'b0;
      area_logic <= 1'b0;
      area_start <= 16'h0000;
      area_end <= 16'h0000;
      area_on <= 16'h0000;
      area_off <= 16'h0000;
    end else begin
      case (state)
        beam_area_pkg::S_FETCH_BOUNDS: begin
          area_enable <= mem_eval_rdata[beam_area_pkg::CTRL_ENABLE_BIT];
          area_logic <= mem_eval_rdata[beam_area_pkg::CTRL_LOGIC_BIT];
        end
        beam_area_pkg::S_FETCH_THRESH: begin
          area_start <= mem_eval_rdata[beam_area_pkg::LOW_HALF_LSB +: 16];
          area_end <= mem_eval_rdata[beam_area_pkg::HIGH_HALF_LSB +: 16];
        end
        beam_area_pkg::S_TAKE_THRESH: begin
          area_on <= mem_eval_rdata[beam_area_pkg::LOW_HALF_LSB +: 16];
          area_off <= mem_eval_rdata[beam_area_pkg::HIGH_HALF_LSB +: 16];
        end
        default: ;
      endcase
    end
  end

  // area state vector, one bit per area
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      area_state <= 32'h0000_0000;
    end else if (state == beam_area_pkg::S_EVAL) begin
      area_state[area_idx] <= next_state_bit;
    end
  end

  // pin outputs, level refreshed once per scan
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pin2_out <= 1'b0;
      pin2_oe <= 1'b0;
      eval_done <= 1'b0;
    end else begin
      pin2_oe <= pin_dir == beam_area_pkg::PIN_AS_OUTPUT;
      eval_done <= state == beam_area_pkg::S_OUTPUT;
      if (state == beam_area_pkg::S_OUTPUT) begin
        pin2_out <= next_pin;
      end
    end
  end
endmodule : beam_area_output_mapping

// ==== verification/beam_area_asserts.sv ====
`timescale 1ns/1ps
// port-level checks of register access, scan timing and pin 2
module beam_area_asserts (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // scan and pin
  input wire logic scan_valid,
  input wire logic pin2_out,
  input wire logic pin2_oe,
  input wire logic eval_done
);
  logic busy;
  logic take;
  // a scan is taken when idle, or in the cycle that shows the previous result
  assign take = scan_valid && (!busy || eval_done);
  // tracks an accepted scan until its result, a new take wins over the clear
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      busy <= 1'b0;
    end else if (take) begin
      busy <= 1'b1;
    end else if (eval_done) begin
      busy <= 1'b0;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  a_done_pulse: assert property (eval_done |=> !eval_done)
    else $error("scan done longer than one cycle");
  a_pin_hold: assert property ($changed(pin2_out) |-> eval_done)
    else $error("pin moved outside a scan result");
  a_scan_time: assert property (take |-> ##[161:164] eval_done)
    else $error("scan result late");
  a_done_cause: assert property (eval_done |-> busy)
    else $error("result without accepted scan");
  a_oe_dir: assert property (
    reg_wr && reg_addr == 8'h00 ##1 !(reg_wr && reg_addr == 8'h00)
    |=> pin2_oe == !$past(reg_wdata[0], 2))
    else $error("output enable not following direction");
  a_oe_release: assert property ($fell(reset) |-> ##1 pin2_oe)
    else $error("pin not driving after reset");
  a_mask_back: assert property (
    reg_wr && reg_addr == 8'h03 ##2 reg_rd && reg_addr == 8'h03
    |=> reg_rdata == $past(reg_wdata, 3))
    else $error("area mask readback wrong");
  a_func_back: assert property (
    reg_wr && reg_addr == 8'h02 ##2 reg_rd && reg_addr == 8'h02
    |=> reg_rdata == {24'h0, $past(reg_wdata[7:0], 3)})
    else $error("output function readback wrong");
  c_scan: cover property (take);
  c_pin_low: cover property (eval_done && !pin2_out);
  c_pin_high: cover property (eval_done && pin2_out);
endmodule : beam_area_asserts
bind beam_area_output_mapping beam_area_asserts chk_i (.sys_clk(sys_clk), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .scan_valid(scan_valid), .pin2_out(pin2_out),
  .pin2_oe(pin2_oe), .eval_done(eval_done));

// ==== verification/pin_reader.sv ====
`timescale 1ns/1ps
// controller input reading pin 2 at each scan result
module pin_reader (
  // clock
  input wire logic sys_clk,
  // pin 2 and result strobe
  input wire logic pin2_out,
  input wire logic pin2_oe,
  input wire logic eval_done,
  // level seen by the controller
  output logic seen
);
  // undriven pin reads low through the pull-down
  always_ff @(posedge sys_clk) begin
    if (eval_done) seen <= pin2_oe ? pin2_out : 1'b0;
  end
endmodule : pin_reader

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic scan_valid = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [63:0] scan_blocked = 64'h0;
  logic [31:0] reg_rdata;
  logic [31:0] rd_val;
  logic pin2_out, pin2_oe, eval_done, seen;
  logic [7:0] rst_addr [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h07};
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  int n;
  // clock
  always #20 sys_clk = ~sys_clk;
  beam_area_output_mapping uut (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .scan_blocked(scan_blocked), .scan_valid(scan_valid), .pin2_out(pin2_out),
    .pin2_oe(pin2_oe), .eval_done(eval_done));
  pin_reader ctl (.sys_clk(sys_clk), .pin2_out(pin2_out), .pin2_oe(pin2_oe),
    .eval_done(eval_done), .seen(seen));
  // verdict
  task complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    rd_val = reg_rdata;
  endtask : rd
  // one scan, optionally a second one while busy, then pin and states
  task scan(input logic [63:0] v, input logic drop, input logic ep, input logic [1:0] es);
    @(posedge sys_clk);
    scan_blocked <= v;
    scan_valid <= 1'b1;
    @(posedge sys_clk);
    scan_valid <= 1'b0;
    if (drop) begin
      repeat (20) @(posedge sys_clk);
      scan_blocked <= ~v;
      scan_valid <= 1'b1;
      @(posedge sys_clk);
      scan_valid <= 1'b0;
    end
    // wait on the falling edge so the result pulse is seen while it stands
    n = 0;
    while (eval_done !== 1'b1 && n < 400) begin
      @(negedge sys_clk);
      n++;
    end
    if (n == 400) begin
      n_mismatch++;
      complete_run();
    end
    chk({31'h0, pin2_out}, {31'h0, ep});
    @(negedge sys_clk);
    chk({31'h0, seen}, {31'h0, ep});
    chk({31'h0, eval_done}, 32'h0);
    rd(8'h04);
    chk({30'h0, rd_val[1:0]}, {30'h0, es});
  endtask : scan
  // main sequence
  initial begin
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    foreach (rst_addr[i]) begin
      rd(rst_addr[i]);
      chk(rd_val, 32'h0);
    end
    for (int i = 0; i < 32; i++) wr(8'h80 + 8'(i * 4), 32'h0);
    wr(8'h00, 32'h0);
    wr(8'h01, 32'h1);
    wr(8'h02, 32'h1);
    rd(8'h02);
    chk(rd_val, 32'h1);
    wr(8'h03, 32'h1);
    rd(8'h03);
    chk(rd_val, 32'h1);
    wr(8'h80, 32'h1);
    wr(8'h81, 32'hfffc_fffe);
    wr(8'h82, 32'h0000_0001);
    rd(8'h81);
    chk(rd_val, 32'hfffc_fffe);
    wr(8'h83, 32'h0000_00a5);
    rd(8'h83);
    chk(rd_val, 32'h0);
    // hole detection on a tracking web, dark pin
    scan(64'h0000_0000_000f_fe00, 1'b0, 1'b1, 2'b00);
    scan(64'h0000_0000_000f_be00, 1'b1, 1'b0, 2'b01);
    rd(8'h05);
    chk(rd_val, 32'h0014_000a);
    scan(64'h0, 1'b0, 1'b1, 2'b00);
    rd(8'h06);
    chk(rd_val, 32'h2);
    scan(64'h0000_0000_000f_be00, 1'b0, 1'b0, 2'b01);
    scan(64'h0003_ffff_e000_0000, 1'b0, 1'b1, 2'b00);
    // fixed area 2 with hysteresis, light pin
    wr(8'h84, 32'h1);
    wr(8'h85, 32'h0008_0001);
    wr(8'h86, 32'h0001_0003);
    wr(8'h03, 32'h2);
    wr(8'h01, 32'h0);
    scan(64'h00, 1'b0, 1'b1, 2'b10);
    scan(64'h3f, 1'b0, 1'b1, 2'b10);
    scan(64'h7f, 1'b0, 1'b0, 2'b00);
    scan(64'h3f, 1'b0, 1'b0, 2'b00);
    scan(64'h1f, 1'b0, 1'b1, 2'b10);
    // counting interrupted beams, then polarity and function
    wr(8'h84, 32'h3);
    scan(64'h01, 1'b0, 1'b0, 2'b00);
    wr(8'h01, 32'h1);
    scan(64'h01, 1'b0, 1'b1, 2'b00);
    wr(8'h01, 32'h0);
    wr(8'h02, 32'h0);
    scan(64'h1f, 1'b0, 1'b0, 2'b10);
    wr(8'h02, 32'h1);
    wr(8'h84, 32'h0);
    scan(64'h1f, 1'b0, 1'b0, 2'b00);
    wr(8'h03, 32'h3);
    scan(64'h0000_0000_000f_be00, 1'b0, 1'b1, 2'b01);
    wr(8'h00, 32'h1);
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({31'h0, pin2_oe}, 32'h0);
    complete_run();
  end
  // hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 10000) begin
      n_mismatch++;
      complete_run();
    end
  end
endmodule : testbench
